// ---- include/adc_chan_defs.vh ----
/*
 * Constants for the converter channel configuration and priority block:
 * register offsets, reset values, field positions and code ranges.
 * Assumes it is included by bare name, once per compilation unit.
 */
`ifndef ADC_CHAN_DEFS_VH
`define ADC_CHAN_DEFS_VH

// Geometry
`define NUM_CH          16
`define NUM_DED         2
`define CH_IDX_W        4
`define CODE_W          12
`define RES_W           16
`define ADDR_W          8

// Register word addresses
`define OFS_ANALOG_SEL  8'h00
`define OFS_DIRECTION   8'h01
`define OFS_PORT_VALUE  8'h02
`define OFS_MODE_LOW    8'h03
`define OFS_MODE_HIGH   8'h04
`define OFS_CORE_INSEL  8'h05
`define OFS_CTRL1_HIGH  8'h06
`define OFS_STATUS      8'h07
`define OFS_RESULT_BASE 8'h10

// Reset values
`define RST_ANALOG_SEL  16'hffff
`define RST_DIRECTION   16'hffff

// Field positions
`define FRAC_BIT        7
`define INSEL_W         2

// Code offsets
`define SE_SIGN_OFS     12'h800
`define PD_UNS_OFS      11'h400
`define INSEL_DEFAULT   2'h0

// Core finish stagger, in source clock periods per higher core
`define STAGGER_PER_CORE 1

`endif

// ---- hdl/adc_channel_config_priority.v ----
/*
 * Channel configuration, result formatting, dedicated core routing and
 * shared core priority arbitration for a multi-core SAR converter: the pin
 * analog select and direction registers, per-channel pseudodiff and sign
 * bits, the dedicated core input selectors, sixteen result buffers and the
 * pending request set of the shared core.
 * Assumes one module clock and pins already synchronous to it; analog
 * cores outside deliver raw 12-bit codes with a one-cycle done pulse and
 * the code valid beside it; the shared core raises busy the cycle after a
 * grant and holds it until its done pulse; the source clock arrives as a
 * one-cycle tick; register strobes come from a simple single-cycle master
 * that never waits.
 */
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "adc_chan_defs.vh"

module adc_channel_config_priority (
   input  wire                   I_REF_CLK,       // Module clock
   input  wire                   I_RST,           // Synchronous reset, active high
   input  wire [`ADDR_W-1:0]     I_ADDR,          // Register word address
   input  wire [15:0]            I_WDATA,         // Write data
   input  wire                   I_WR,            // Write strobe
   input  wire                   I_RD,            // Read strobe
   output reg  [15:0]            O_RDATA,         // Read data, cycle after strobe
   input  wire [`NUM_CH-1:0]     I_PIN_LEVEL,     // Digital level seen on each pin
   input  wire [`NUM_CH-1:0]     I_PORT_OUT,      // Digital port output latch
   output wire [`NUM_CH-1:0]     O_PIN_OUT_EN,    // Port drives pin when high
   output wire [`NUM_CH-1:0]     O_DIG_IBUF_EN,   // Digital input buffer enable
   output wire [`NUM_CH-1:0]     O_ANALOG_CONNECT, // Pin routed to converter
   input  wire [`NUM_CH-1:0]     I_CH_TRIGGER,    // Per-channel trigger pulses
   output wire [`NUM_DED-1:0]    O_DED_TRIGGER,   // Trigger to each dedicated core
   output wire [2*`NUM_DED-1:0]  O_DED_INSEL,     // Analog source per dedicated core
   output wire [`NUM_CH-1:0]     O_CH_DIFF,       // Per-channel pseudodiff mode
   output wire                   O_SHR_REQ,       // Shared core conversion request
   output reg  [`CH_IDX_W-1:0]   O_SHR_CH,        // Channel for shared core
   input  wire                   I_SHR_BUSY,      // Shared core busy
   input  wire [`NUM_DED:0]      I_CORE_DONE,     // Done per core; top is shared
   input  wire [(`NUM_DED+1)*`CODE_W-1:0] I_CORE_CODE, // Raw unsigned codes
   input  wire                   I_SRC_TICK       // Core source clock enable pulse
);

   // Core count: dedicated cores first, the shared core takes the last
   // index. The core index doubles as the store priority, lowest first,
   // so two cores finishing together never store in the same tick.
   localparam NCORE = `NUM_DED + 1;

   // Software-visible configuration registers
   reg  [15:0]             analog_sel_r;          // Pin analog select
   reg  [15:0]             direction_r;           // Pin direction, 1 = input
   reg  [15:0]             diff_r;                // Per-channel pseudodiff enable
   reg  [15:0]             sign_r;                // Per-channel signed result
   reg  [2*`NUM_DED-1:0]   insel_r;               // Dedicated core input select
   reg                     frac_r;                // Fractional format select
   reg  [`RES_W-1:0]       result_r [0:`NUM_CH-1]; // Channel result buffers
   // Arbitration, capture and store state
   reg  [`NUM_CH-1:0]      pend_r;                // Pending shared requests
   reg  [`NUM_CH-1:0]      pend_nxt;
   reg  [NCORE-1:0]        wait_r;                // Finished cores awaiting store
   reg  [NCORE*`CODE_W-1:0] code_r;               // Captured raw codes
   reg  [`CH_IDX_W-1:0]    shr_ch_r;              // Channel in shared conversion
   reg  [`CH_IDX_W-1:0]    shr_done_ch_r;         // Channel of the finished shared conversion
   integer                 k;                     // Loop index, clocked process
   integer                 m;                     // Loop index, store selection

   // Sign and mode formatting of a raw code
   // Single-ended: unsigned passes the code through, signed moves the
   // midpoint to zero. Pseudodiff keeps half the scale, starting 1024 above
   // zero when unsigned and straddling zero when signed. The fractional
   // option left-justifies the 12-bit value in the 16-bit buffer.
   function [`RES_W-1:0] fmt_code;
      input [`CODE_W-1:0] raw;
      input               pdiff;
      input               signed_res;
      input               frac;
      reg   [`CODE_W-1:0] v;
      begin
         v = raw;
         if (pdiff) begin
            // Pseudodiff spans half scale around midpoint
            v = {1'b0, raw[`CODE_W-1:1]};
            v = signed_res ? (v - {1'b0, `PD_UNS_OFS}) : (v + {1'b0, `PD_UNS_OFS});
         end else if (signed_res) begin
            v = raw - `SE_SIGN_OFS;
         end
         if (frac) begin
            fmt_code = {v, 4'h0};                             // Left-justified
         end else if (signed_res) begin
            fmt_code = {{4{v[`CODE_W-1]}}, v};
         end else begin
            fmt_code = {4'h0, v};
         end
      end
   endfunction

   // Index of lowest set request bit
   // Scanned from the top so the last hit, the lowest index, is kept
   function [`CH_IDX_W-1:0] lowest_idx;
      input [`NUM_CH-1:0] req;
      integer j;
      begin
         lowest_idx = {`CH_IDX_W{1'b0}};
         for (j = `NUM_CH-1; j >= 0; j = j - 1) begin
            if (req[j]) begin
               lowest_idx = j[`CH_IDX_W-1:0];
            end
         end
      end
   endfunction

   // Mode registers hold two bits per channel, eight channels a word:
   // bit 2i is the pseudodiff enable and bit 2i+1 the sign select of
   // channel i, or of channel i+8 in the high word.

   // Even bits of a mode word: pseudodiff enables of eight channels
   function [7:0] even_bits;
      input [15:0] w;
      integer i;
      begin
         even_bits = 8'h00;
         for (i = 0; i < 8; i = i + 1) begin
            even_bits[i] = w[2*i];
         end
      end
   endfunction

   // Odd bits of a mode word: sign selects of eight channels
   function [7:0] odd_bits;
      input [15:0] w;
      integer i;
      begin
         odd_bits = 8'h00;
         for (i = 0; i < 8; i = i + 1) begin
            odd_bits[i] = w[2*i+1];
         end
      end
   endfunction

   // Mode word rebuilt from eight pseudodiff and eight sign bits
   function [15:0] mode_word;
      input [7:0] dbits;
      input [7:0] sbits;
      integer i;
      begin
         mode_word = 16'h0000;
         for (i = 0; i < 8; i = i + 1) begin
            mode_word[2*i]   = dbits[i];
            mode_word[2*i+1] = sbits[i];
         end
      end
   endfunction

   // Pin control outputs, all straight from registers so they never glitch.
   // An analog pin loses its digital input buffer and draws no current there.
   // Clearing a direction bit lets the port latch drive the pin; the core
   // then samples that driven level like any other voltage, so the latch
   // needs no path through this block.
   assign O_DIG_IBUF_EN    = ~analog_sel_r;
   assign O_ANALOG_CONNECT = analog_sel_r;
   assign O_PIN_OUT_EN     = ~direction_r;
   assign O_CH_DIFF        = diff_r;

   // Dedicated cores: the selector only moves the analog switch; the
   // trigger stays with the core's own channel whatever is written, and
   // the selector bits pass to the switch unchanged.
   genvar g;
   generate
      for (g = 0; g < `NUM_DED; g = g + 1) begin : g_ded
         // Trigger always from the core's own channel
         assign O_DED_TRIGGER[g] = I_CH_TRIGGER[g];
         assign O_DED_INSEL[2*g+1:2*g] = insel_r[2*g+1:2*g];
      end
   endgenerate

   // Shared core requests: dedicated channels are excluded
   // A request is offered only while the core is idle, so a grant is
   // taken in the cycle it shows and the core answers with busy next.
   wire [`NUM_CH-1:0] shr_mask = {{(`NUM_CH-`NUM_DED){1'b1}}, {`NUM_DED{1'b0}}};
   wire [`NUM_CH-1:0] shr_pend = pend_r & shr_mask;
   assign O_SHR_REQ = (|shr_pend) & ~I_SHR_BUSY;

   // Lowest pending shared channel wins; zero while nothing waits
   always @* begin
      O_SHR_CH = lowest_idx(shr_pend);
   end

   // Pending set wins over grant clear
   // A trigger that lands in the grant cycle of the same channel re-arms
   // it, so no request is lost; a granted bit is cleared exactly once,
   // so none is converted twice.
   always @* begin
      pend_nxt = pend_r;
      if (O_SHR_REQ) begin
         pend_nxt[O_SHR_CH] = 1'b0;
      end
      pend_nxt = pend_nxt | (I_CH_TRIGGER & shr_mask);
   end

   // Lowest finished core index stores first
   // A core waits in wait_r from the cycle after its done pulse until
   // its store tick. One core stores per tick, so a core waits one more
   // source period for each finished core ahead of it.
   // Two bits of store_core cover all three cores.
   wire [NCORE-1:0] wait_all = wait_r | I_CORE_DONE;
   reg  [1:0]       store_core;
   reg              store_any;
   always @* begin
      store_core = 2'h0;
      store_any  = 1'b0;
      for (m = NCORE-1; m >= 0; m = m - 1) begin
         if (wait_r[m]) begin
            store_core = m[1:0];
            store_any  = 1'b1;
         end
      end
   end

   // Registers, result storage and arbitration state.
   // Reset is synchronous: pins come up analog and as inputs, every
   // channel single-ended and unsigned, selectors on their first source,
   // no request pending and no result waiting. Result buffers clear too
   // so a read before the first conversion shows zero.
   always @(posedge I_REF_CLK) begin
      if (I_RST) begin
         analog_sel_r <= `RST_ANALOG_SEL;
         direction_r  <= `RST_DIRECTION;
         diff_r       <= 16'h0000;
         sign_r       <= 16'h0000;
         insel_r      <= {`NUM_DED{`INSEL_DEFAULT}};
         frac_r       <= 1'b0;
         pend_r       <= 16'h0000;
         wait_r       <= {NCORE{1'b0}};
         code_r       <= {NCORE*`CODE_W{1'b0}};
         shr_ch_r     <= 4'h0;
         shr_done_ch_r <= 4'h0;
         O_RDATA      <= 16'h0000;
         for (k = 0; k < `NUM_CH; k = k + 1) begin
            result_r[k] <= 16'h0000;
         end
      end else begin
         // Pending shared requests advance every cycle
         pend_r      <= pend_nxt;
         if (O_SHR_REQ) begin
            shr_ch_r <= O_SHR_CH;                             // Remember granted channel
         end
         // The next grant may come in the very cycle of the done pulse and
         // overwrite shr_ch_r, so the finished channel is kept apart
         if (I_CORE_DONE[`NUM_DED]) begin
            shr_done_ch_r <= shr_ch_r;
         end
         // Capture codes of newly finished cores
         // The code bus is valid only with done, so it is latched at once
         for (k = 0; k < NCORE; k = k + 1) begin
            if (I_CORE_DONE[k]) begin
               code_r[k*`CODE_W +: `CODE_W] <= I_CORE_CODE[k*`CODE_W +: `CODE_W];
            end
         end
         // One store per source clock period, highest priority first
         // Ticks are one core source period apart, which paces the stagger
         if (I_SRC_TICK && store_any) begin
            if (store_core == `NUM_DED) begin
               // Shared core result goes to the channel it converted
               result_r[shr_done_ch_r] <= fmt_code(code_r[store_core*`CODE_W +: `CODE_W],
                                          diff_r[shr_done_ch_r], sign_r[shr_done_ch_r], frac_r);
            end else begin
               // Dedicated core k always fills buffer k, whatever its selector
               result_r[store_core] <= fmt_code(code_r[store_core*`CODE_W +: `CODE_W],
                                       diff_r[store_core], sign_r[store_core], frac_r);
            end
            // Stored core leaves the wait set, newly finished ones join it
            wait_r <= wait_all & ~({{(NCORE-1){1'b0}}, 1'b1} << store_core);
         end else begin
            // No store this cycle: finished cores keep waiting
            wait_r <= wait_all;
         end
         // Register writes; unmapped addresses are ignored
         // Writes take effect at the strobe edge
         if (I_WR) begin
            case (I_ADDR)
               `OFS_ANALOG_SEL: analog_sel_r <= I_WDATA;
               `OFS_DIRECTION:  direction_r  <= I_WDATA;
               // Mode words: even bits pseudodiff, odd bits sign
               `OFS_MODE_LOW: begin
                  diff_r[7:0]  <= even_bits(I_WDATA);
                  sign_r[7:0]  <= odd_bits(I_WDATA);
               end
               `OFS_MODE_HIGH: begin
                  diff_r[15:8] <= even_bits(I_WDATA);
                  sign_r[15:8] <= odd_bits(I_WDATA);
               end
               // Selector changes the analog source only
               `OFS_CORE_INSEL: insel_r <= I_WDATA[2*`NUM_DED-1:0];
               `OFS_CTRL1_HIGH: frac_r  <= I_WDATA[`FRAC_BIT];
               default: ;                                     // Unmapped write
            endcase
         end
         // Register reads, data one cycle later and zero otherwise,
         // so a back-to-back read simply replaces the previous word
         if (I_RD) begin
            if (I_ADDR >= `OFS_RESULT_BASE && I_ADDR < `OFS_RESULT_BASE + `NUM_CH) begin
               // Result buffers sit at consecutive word addresses
               O_RDATA <= result_r[I_ADDR[`CH_IDX_W-1:0]];
            end else begin
               case (I_ADDR)
                  `OFS_ANALOG_SEL: O_RDATA <= analog_sel_r;
                  `OFS_DIRECTION:  O_RDATA <= direction_r;
                  // Analog pins read zero whatever their voltage
                  `OFS_PORT_VALUE: O_RDATA <= I_PIN_LEVEL & ~analog_sel_r;
                  `OFS_MODE_LOW:   O_RDATA <= mode_word(diff_r[7:0], sign_r[7:0]);
                  `OFS_MODE_HIGH:  O_RDATA <= mode_word(diff_r[15:8], sign_r[15:8]);
                  `OFS_CORE_INSEL: O_RDATA <= {12'h000, insel_r};
                  `OFS_CTRL1_HIGH: O_RDATA <= {8'h00, frac_r, 7'h00};
                  // Pending shared requests, for software to poll
                  `OFS_STATUS:     O_RDATA <= pend_r;
                  default:         O_RDATA <= 16'h0000; // Unmapped read
               endcase
            end
         end else begin
            // Idle bus reads back zero
            O_RDATA <= 16'h0000;
         end
      end
   end

endmodule
`default_nettype wire

// ---- bench/adc_chan_monitor.sv ----
/* Checker for the channel configuration block: pin selection, mode routing
   and shared core arbitration. Assumes it is bound to the top module. */
`timescale 1ns/1ps
`default_nettype none
`include "adc_chan_defs.vh"
module adc_chan_monitor (
   input wire logic        I_REF_CLK,
   input wire logic        I_RST,
   input wire logic [7:0]  I_ADDR,
   input wire logic [15:0] I_WDATA,
   input wire logic        I_WR,
   input wire logic        I_RD,
   input wire logic [15:0] O_RDATA,
   input wire logic [15:0] O_PIN_OUT_EN,
   input wire logic [15:0] O_DIG_IBUF_EN,
   input wire logic [15:0] O_ANALOG_CONNECT,
   input wire logic [15:0] I_CH_TRIGGER,
   input wire logic [1:0]  O_DED_TRIGGER,
   input wire logic [3:0]  O_DED_INSEL,
   input wire logic [15:0] O_CH_DIFF,
   input wire logic        O_SHR_REQ,
   input wire logic [3:0]  O_SHR_CH,
   input wire logic        I_SHR_BUSY
);
   // One clock domain, reset disables every check
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (I_RST);
   a_ibuf_off_analog: assert property (O_DIG_IBUF_EN == ~O_ANALOG_CONNECT)
      else $error("input buffer on for analog pin");
   a_rst_analog_set: assert property ($past(I_RST) |-> O_ANALOG_CONNECT == 16'hffff)
      else $error("analog select not set after reset");
   a_rst_dir_input: assert property ($past(I_RST) |-> O_PIN_OUT_EN == 16'h0000)
      else $error("pin not input after reset");
   a_sel_write_bit: assert property (I_WR && I_ADDR == `OFS_ANALOG_SEL |=> O_ANALOG_CONNECT == $past(I_WDATA))
      else $error("analog select write not applied");
   a_port_analog_zero: assert property ($past(I_RD) && !$past(I_RST) && $past(I_ADDR) == `OFS_PORT_VALUE
      |-> (O_RDATA & $past(O_ANALOG_CONNECT)) == 16'h0000)
      else $error("analog pin reads nonzero");
   a_diff_mode_bit: assert property (I_WR && I_ADDR == `OFS_MODE_LOW
      |=> O_CH_DIFF[0] == $past(I_WDATA[0]) && O_CH_DIFF[2] == $past(I_WDATA[4]))
      else $error("differential bit not applied");
   a_ded_trig_fixed: assert property (O_DED_TRIGGER == I_CH_TRIGGER[1:0])
      else $error("dedicated trigger not from own channel");
   a_insel_route: assert property (I_WR && I_ADDR == `OFS_CORE_INSEL |=> O_DED_INSEL == $past(I_WDATA[3:0]))
      else $error("input selector write not applied");
   a_shr_low_first: assert property (I_CH_TRIGGER[2] ##1 !I_SHR_BUSY |-> O_SHR_REQ && O_SHR_CH == 4'h2)
      else $error("lowest channel not granted");
   a_shr_pending_kept: assert property ((|I_CH_TRIGGER[15:2]) |=> I_SHR_BUSY || O_SHR_REQ)
      else $error("shared request lost");
   a_shr_never_ded: assert property (O_SHR_REQ |-> O_SHR_CH >= 4'h2 && !I_SHR_BUSY)
      else $error("bad shared grant");
endmodule
bind adc_channel_config_priority adc_chan_monitor u_mon (.I_REF_CLK(I_REF_CLK), .I_RST(I_RST),
   .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
   .O_PIN_OUT_EN(O_PIN_OUT_EN), .O_DIG_IBUF_EN(O_DIG_IBUF_EN), .O_ANALOG_CONNECT(O_ANALOG_CONNECT),
   .I_CH_TRIGGER(I_CH_TRIGGER), .O_DED_TRIGGER(O_DED_TRIGGER), .O_DED_INSEL(O_DED_INSEL),
   .O_CH_DIFF(O_CH_DIFF), .O_SHR_REQ(O_SHR_REQ), .O_SHR_CH(O_SHR_CH), .I_SHR_BUSY(I_SHR_BUSY));
`default_nettype wire

// ---- bench/adc_core_model.sv ----
/* Model of the analog cores: two dedicated, one shared, each converting
   for LAT cycles. Assumes one module clock; the code bus is valid only
   while done is high. */
`timescale 1ns/1ps
`default_nettype none
module adc_core_model #(parameter int LAT = 6) (
   input  wire logic        clk,      // Module clock
   input  wire logic        rst,      // Reset, active high
   input  wire logic [1:0]  ded_go,   // Dedicated core triggers
   input  wire logic        shr_go,   // Shared core grant
   input  wire logic [11:0] code,     // Raw code to return
   output logic             busy,     // Shared core converting
   output logic [2:0]       done,     // Done pulse per core
   output logic [35:0]      code_bus, // Codes, inverted outside done
   output logic             tick      // Source clock enable
);
   int         cnt [3];               // Cycles left per core
   logic [2:0] go;                    // Start request per core
   assign go = {shr_go, ded_go};
   // Count each conversion down and pulse done with the code at the end
   always @(posedge clk) begin
      tick <= rst ? 1'b0 : ~tick;
      busy <= !rst && (go[2] || cnt[2] > 1);
      for (int k = 0; k < 3; k++) begin
         done[k] <= !rst && cnt[k] == 1;
         code_bus[12*k +: 12] <= (cnt[k] == 1) ? code : ~code;
         if (rst)
            cnt[k] <= 0;
         else if (cnt[k] > 0)
            cnt[k] <= cnt[k] - 1;
         else if (go[k])
            cnt[k] <= LAT;
      end
   end
endmodule
`default_nettype wire

// ---- bench/adc_channel_config_priority_bench.sv ----
/* Bench: reset values, then result format table, dedicated core, priority and
   pin register cases. Assumes the core model answers every trigger. */
`timescale 1ns/1ps
`default_nettype none
`include "adc_chan_defs.vh"
module adc_channel_config_priority_bench;
   logic        clk, rst, wr, rd, busy, tick, sreq;
   logic [7:0]  addr;
   logic [15:0] wdata, rdata, pins, trig, ibuf, oen, d;
   logic [1:0]  dtrig;
   logic [3:0]  insel, sch;
   logic [2:0]  done;
   logic [35:0] cbus;
   logic [11:0] code;
   logic [3:0]  grants [$];
   int          num_errors = 0, n_tests = 0, cyc = 0;
   // Rows: diff, sign, raw code, expected result
   logic [29:0] rows [8] = '{{2'b00,12'h000,16'h0000}, {2'b00,12'hfff,16'h0fff},
      {2'b01,12'h000,16'hf800}, {2'b01,12'hfff,16'h07ff}, {2'b10,12'h000,16'h0400},
      {2'b10,12'hfff,16'h0bff}, {2'b11,12'h000,16'hfc00}, {2'b11,12'hfff,16'h03ff}};
   logic [7:0]  pexp [3] = '{8'h03, 8'h05, 8'h09};
   adc_channel_config_priority u_dut (.I_REF_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_PIN_LEVEL(pins), .I_PORT_OUT(16'h0000),
      .O_PIN_OUT_EN(oen), .O_DIG_IBUF_EN(ibuf), .O_ANALOG_CONNECT(), .I_CH_TRIGGER(trig),
      .O_DED_TRIGGER(dtrig), .O_DED_INSEL(insel), .O_CH_DIFF(), .O_SHR_REQ(sreq), .O_SHR_CH(sch),
      .I_SHR_BUSY(busy), .I_CORE_DONE(done), .I_CORE_CODE(cbus), .I_SRC_TICK(tick));
   adc_core_model u_cores (.clk(clk), .rst(rst), .ded_go(dtrig), .shr_go(sreq), .code(code),
      .busy(busy), .done(done), .code_bus(cbus), .tick(tick));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Hang guard and log of shared core grants
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (sreq === 1'b1)
         grants.push_back(sch);
      if (cyc == 20000) begin
         num_errors++;
         stop_test;
      end
   end
   task automatic wreg(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rreg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Wait for a done pulse of core k, then let the store land
   task automatic wdone(input int k);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (done[k] !== 1'b1 && n < 60);
      repeat (6) @(posedge clk);
   endtask
   task automatic fire(input logic [15:0] t, input int k);
      @(posedge clk);
      trig <= t;
      @(posedge clk);
      trig <= 16'h0000;
      wdone(k);
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 16'h0000;
      pins = 16'h0000;
      trig = 16'h0000;
      code = 12'h000;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rreg(`OFS_ANALOG_SEL);
      chk(d, 16'hffff);
      rreg(`OFS_DIRECTION);
      chk(d, 16'hffff);
      $display("reset values done");
      foreach (rows[i]) begin
         wreg(`OFS_MODE_LOW, {10'h000, rows[i][28], rows[i][29], 4'h0});
         code = rows[i][27:16];
         fire(16'h0004, 2);
         rreg(`OFS_RESULT_BASE + 8'h02);
         chk(d, rows[i][15:0]);
      end
      $display("format table done");
      // Selector moved away, triggers and buffers must stay fixed
      wreg(`OFS_CORE_INSEL, 16'h000f);
      chk({12'h000, insel}, 16'h000f);
      code = 12'h9a5;
      fire(16'h0003, 0);
      rreg(`OFS_RESULT_BASE);
      chk(d, 16'h09a5);
      rreg(`OFS_RESULT_BASE + 8'h01);
      chk(d, 16'h09a5);
      $display("dedicated cores done");
      // Three simultaneous shared requests
      code = 12'h3c3;
      grants.delete();
      fire(16'h0228, 2);
      wdone(2);
      wdone(2);
      chk(16'(grants.size()), 16'h0003);
      for (int i = 0; i < 3; i++) begin
         chk({12'h000, grants[i]}, {8'h00, pexp[i]});
         rreg(`OFS_RESULT_BASE + pexp[i]);
         chk(d, 16'h03c3);
      end
      $display("priority done");
      rreg(`OFS_STATUS);
      chk(d, 16'h0000);
      wreg(`OFS_MODE_HIGH, 16'h0003);
      rreg(`OFS_MODE_HIGH);
      chk(d, 16'h0003);
      wreg(`OFS_CTRL1_HIGH, 16'h0080);
      rreg(`OFS_CTRL1_HIGH);
      chk(d, 16'h0080);
      code = 12'h9a5;
      fire(16'h0008, 2);
      rreg(`OFS_RESULT_BASE + 8'h03);
      chk(d, 16'h9a50);
      wreg(`OFS_CTRL1_HIGH, 16'h0000);
      $display("fractional and status done");
      pins <= 16'hffff;
      wreg(`OFS_ANALOG_SEL, 16'h00ff);
      chk(ibuf, 16'hff00);
      rreg(`OFS_PORT_VALUE);
      chk(d, 16'hff00);
      wreg(`OFS_DIRECTION, 16'h0000);
      chk(oen, 16'hffff);
      rreg(8'h08);
      chk(d, 16'h0000);
      $display("pin registers done");
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rreg(`OFS_ANALOG_SEL);
      chk(d, 16'hffff);
      rreg(`OFS_DIRECTION);
      chk(d, 16'hffff);
      $display("second reset done");
      stop_test;
   end
endmodule
`default_nettype wire
